/* arb_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface arb_if;
   logic [dma_pkg::NUM_CH-1:0] req;
   dma_pkg::prio_type [dma_pkg::NUM_CH-1:0] prio;
   logic [dma_pkg::CH_IDX_W-1:0] grant_idx;
   logic grant_valid;

   modport arbiter (input req, input prio, output grant_idx, output grant_valid);
   modport client (output req, output prio, input grant_idx, input grant_valid);
endinterface
`default_nettype wire

/* dma_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Far-side bus slave: memories and peripherals in one byte space
// ---------------------------------------------------------------
module dma_mem_model (
   input wire logic clk,              // System clock
   input wire logic bus_req,          // Access request
   input wire logic bus_we,           // Write when high
   input wire logic [1:0] bus_size,   // Access size
   input wire logic [31:0] bus_addr,  // Byte address
   input wire logic [31:0] bus_wdata, // Right-justified write data
   input wire logic [1:0] wait_cyc,   // Extra answer latency
   input wire logic [31:0] err_addr,  // Address that fails
   output logic [31:0] bus_rdata,     // Right-justified read data
   output logic bus_ack,              // Access done, one cycle
   output logic bus_err               // Access failed, one cycle
);
   logic [7:0] mem [logic [31:0]];
   logic [31:0] a;
   int cnt = 0;
   int n;
   initial {bus_ack, bus_err, bus_rdata} = '0;
   always @(posedge clk) begin
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      // Lines never keep stale data between answers
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_ack && !bus_err) begin
         if (cnt < int'(wait_cyc)) cnt <= cnt + 1;
         else if (bus_addr == err_addr) begin
            cnt <= 0;
            bus_err <= 1'b1;
         end else begin
            cnt <= 0;
            bus_ack <= 1'b1;
            n = (bus_size == 2'h0) ? 1 : (bus_size == 2'h1) ? 2 : 4;
            for (int i = 0; i < n; i++) begin
               a = bus_addr + 32'(i);
               if (bus_we) mem[a] = bus_wdata[8*i +: 8];
               else bus_rdata[8*i +: 8] <= mem.exists(a) ? mem[a] : (a[7:0] ^ 8'hA5);
            end
         end
      end
   end
endmodule // dma_mem_model
`default_nettype wire

/* dma_pkg.sv */
`default_nettype none
package dma_pkg;
   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NUM_CH = 7;
   localparam int CH_IDX_W = 3;
   localparam int NUM_PERIPH = 16;
   localparam int NUM_TRIG = 8;
   localparam int SEL_W = 5;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int CNT_W = 17;
   localparam int NUM_FLAGS = 3;

   // ---------------------------------------------------------------
   // Field positions and encodings
   // ---------------------------------------------------------------
   localparam int FLAG_HT = 0;
   localparam int FLAG_TC = 1;
   localparam int FLAG_TE = 2;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
   localparam logic [31:0] MASK_HALF = 32'h0000_FFFF;
   localparam logic [31:0] MASK_WORD = 32'hFFFF_FFFF;
   localparam logic [2:0] BEAT_RST = 3'h0;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;

   typedef enum logic [1:0] {PRIO_LOW, PRIO_MEDIUM, PRIO_HIGH, PRIO_VERY_HIGH} prio_type;
   typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} eng_type;
endpackage
`default_nettype wire

/* dma_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dma_top #(
   parameter int N_PERIPH = dma_pkg::NUM_PERIPH,  // Peripheral request lines
   parameter int N_TRIG = dma_pkg::NUM_TRIG       // Hardware trigger lines
) (
   input wire logic clk,                                                   // System clock
   input wire logic ce,                                                    // Clock enable, freezes all state
   input wire logic resetn,                                                // Synchronous reset, active low
   input wire logic [N_PERIPH-1:0] periph_req,                             // Peripheral request pins
   input wire logic [N_TRIG-1:0] hw_trig,                                  // Hardware trigger pins
   input wire logic [dma_pkg::NUM_CH-1:0] ch_enable,                       // Channel enable, rise starts
   input wire logic [dma_pkg::NUM_CH-1:0] ch_circular,                     // Circular mode
   input wire logic [dma_pkg::NUM_CH-1:0] ch_mem2mem,                      // Run without request line
   input wire logic [dma_pkg::NUM_CH-1:0] ch_src_inc,                      // Source address steps
   input wire logic [dma_pkg::NUM_CH-1:0] ch_dst_inc,                      // Destination address steps
   input wire dma_pkg::prio_type [dma_pkg::NUM_CH-1:0] ch_prio,            // Software level
   input wire logic [dma_pkg::NUM_CH-1:0][1:0] ch_src_size,                // Source element size
   input wire logic [dma_pkg::NUM_CH-1:0][1:0] ch_dst_size,                // Destination element size
   input wire logic [dma_pkg::NUM_CH-1:0][dma_pkg::SEL_W-1:0] ch_req_sel,  // Router line select
   input wire logic [dma_pkg::NUM_CH-1:0][dma_pkg::ADDR_W-1:0] ch_src_addr, // Start source address
   input wire logic [dma_pkg::NUM_CH-1:0][dma_pkg::ADDR_W-1:0] ch_dst_addr, // Start destination address
   input wire logic [dma_pkg::NUM_CH-1:0][dma_pkg::CNT_W-1:0] ch_count,    // Element count, 1 to 65536
   input wire logic [dma_pkg::NUM_CH-1:0][dma_pkg::NUM_FLAGS-1:0] flag_clear, // Flag clear pulses
   output logic bus_req,                                                   // Bus access request
   output logic bus_we,                                                    // Write when high
   output logic [1:0] bus_size,                                            // Access size
   output logic [dma_pkg::ADDR_W-1:0] bus_addr,                            // Byte address
   output logic [dma_pkg::DATA_W-1:0] bus_wdata,                           // Right-justified write data
   input wire logic [dma_pkg::DATA_W-1:0] bus_rdata,                       // Right-justified read data
   input wire logic bus_ack,                                               // Access done, one cycle
   input wire logic bus_err,                                               // Access failed, one cycle
   output logic [dma_pkg::NUM_CH-1:0][dma_pkg::NUM_FLAGS-1:0] ch_flags,    // Half, complete, error
   output logic [dma_pkg::NUM_CH-1:0] ch_irq,                              // Per-channel interrupt
   output logic [dma_pkg::NUM_CH-1:0] ch_active                            // Channel running
);
   localparam int NL = N_PERIPH + N_TRIG;

   typedef struct packed {
      logic [NL-1:0] line_s1;
      logic [NL-1:0] line_s2;
      logic [NL-1:0] line_d;
      logic [dma_pkg::NUM_CH-1:0] en_d;
      logic [dma_pkg::NUM_CH-1:0] active;
      logic [dma_pkg::NUM_CH-1:0] pend;
      logic [dma_pkg::NUM_CH-1:0][dma_pkg::ADDR_W-1:0] src;
      logic [dma_pkg::NUM_CH-1:0][dma_pkg::ADDR_W-1:0] dst;
      logic [dma_pkg::NUM_CH-1:0][dma_pkg::CNT_W-1:0] rem;
      logic [dma_pkg::NUM_CH-1:0][dma_pkg::NUM_FLAGS-1:0] flags;
      logic [dma_pkg::NUM_CH-1:0] irq;
      dma_pkg::eng_type eng;
      logic [dma_pkg::CH_IDX_W-1:0] cur;
      logic [2:0] beat;
      logic [dma_pkg::DATA_W-1:0] pack;
      logic bus_req;
      logic bus_we;
      logic [1:0] bus_size;
      logic [dma_pkg::ADDR_W-1:0] bus_addr;
      logic [dma_pkg::DATA_W-1:0] bus_wdata;
   } st_type;

   st_type st_ff, nxt_st;
   logic [NL-1:0] rise;
   logic [dma_pkg::NUM_CH-1:0] routed_rise;
   logic [1:0] lg_s, lg_d, lg_u;
   logic [2:0] step_s, step_d, unit_bytes;
   logic [dma_pkg::DATA_W-1:0] rd_mask;
   logic unit_done;
   logic [dma_pkg::CNT_W-1:0] rem_dec;

   arb_if arb ();

   prio_arbiter u_arb (
      .clk(clk),
      .resetn(resetn),
      .a(arb.arbiter)
   );

   function automatic logic [1:0] size_log(input logic [1:0] s);
      return (s > dma_pkg::SIZE_WORD) ? dma_pkg::SIZE_WORD : s;
   endfunction

   // ---------------------------------------------------------------
   // Router and arbiter requests
   // ---------------------------------------------------------------
   assign rise = st_ff.line_s2 & ~st_ff.line_d;

   generate
      for (genvar g = 0; g < dma_pkg::NUM_CH; g++) begin : g_route
         // Out-of-range selects route nothing
         assign routed_rise[g] = (int'(ch_req_sel[g]) < NL) ? rise[ch_req_sel[g]] : 1'b0;
         assign arb.req[g] = st_ff.active[g] & (ch_mem2mem[g] | st_ff.pend[g]) &
                             (st_ff.eng == dma_pkg::ENG_IDLE);
         assign arb.prio[g] = ch_prio[g];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Engine sizing
   // ---------------------------------------------------------------
   assign lg_s = size_log(ch_src_size[st_ff.cur]);
   assign lg_d = size_log(ch_dst_size[st_ff.cur]);
   assign lg_u = (lg_s > lg_d) ? lg_s : lg_d;
   assign step_s = 3'h1 << lg_s;
   assign step_d = 3'h1 << lg_d;
   assign unit_bytes = 3'h1 << lg_u;
   assign rd_mask = (lg_s == dma_pkg::SIZE_BYTE) ? dma_pkg::MASK_BYTE :
                    (lg_s == dma_pkg::SIZE_HALF) ? dma_pkg::MASK_HALF : dma_pkg::MASK_WORD;
   assign unit_done = st_ff.eng == dma_pkg::ENG_WRITE && st_ff.bus_req && bus_ack && !bus_err &&
                      (st_ff.beat + step_d == unit_bytes);
   assign rem_dec = st_ff.rem[st_ff.cur] - dma_pkg::CNT_W'(1);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.line_s1 = {hw_trig, periph_req};
      nxt_st.line_s2 = st_ff.line_s1;
      nxt_st.line_d = st_ff.line_s2;
      nxt_st.en_d = ch_enable;
      for (int i = 0; i < dma_pkg::NUM_CH; i++)
         nxt_st.flags[i] = st_ff.flags[i] & ~flag_clear[i];

      case (st_ff.eng)
         dma_pkg::ENG_IDLE: begin
            if (arb.grant_valid) begin
               nxt_st.cur = arb.grant_idx;
               nxt_st.pend[arb.grant_idx] = 1'b0;
               nxt_st.eng = dma_pkg::ENG_READ;
               nxt_st.beat = dma_pkg::BEAT_RST;
               nxt_st.pack = '0;
               nxt_st.bus_req = 1'b1;
               nxt_st.bus_we = 1'b0;
               nxt_st.bus_addr = st_ff.src[arb.grant_idx];
               nxt_st.bus_size = size_log(ch_src_size[arb.grant_idx]);
            end
         end
         dma_pkg::ENG_READ: begin
            if (bus_err) begin
               nxt_st.flags[st_ff.cur][dma_pkg::FLAG_TE] = 1'b1;
               nxt_st.active[st_ff.cur] = 1'b0;
               nxt_st.eng = dma_pkg::ENG_IDLE;
               nxt_st.bus_req = 1'b0;
            end else if (bus_ack) begin
               // Little-endian packing of narrow reads into one unit
               nxt_st.pack = st_ff.pack | ((bus_rdata & rd_mask) << {st_ff.beat[1:0], 3'h0});
               if (ch_src_inc[st_ff.cur])
                  nxt_st.src[st_ff.cur] = st_ff.src[st_ff.cur] + dma_pkg::ADDR_W'(step_s);
               nxt_st.bus_addr = nxt_st.src[st_ff.cur];
               nxt_st.beat = st_ff.beat + step_s;
               if (st_ff.beat + step_s == unit_bytes) begin
                  nxt_st.eng = dma_pkg::ENG_WRITE;
                  nxt_st.beat = dma_pkg::BEAT_RST;
                  nxt_st.bus_we = 1'b1;
                  nxt_st.bus_size = lg_d;
                  nxt_st.bus_addr = st_ff.dst[st_ff.cur];
                  nxt_st.bus_wdata = nxt_st.pack;
               end
            end
         end
         dma_pkg::ENG_WRITE: begin
            if (bus_err) begin
               nxt_st.flags[st_ff.cur][dma_pkg::FLAG_TE] = 1'b1;
               nxt_st.active[st_ff.cur] = 1'b0;
               nxt_st.eng = dma_pkg::ENG_IDLE;
               nxt_st.bus_req = 1'b0;
               nxt_st.bus_we = 1'b0;
            end else if (bus_ack) begin
               if (ch_dst_inc[st_ff.cur])
                  nxt_st.dst[st_ff.cur] = st_ff.dst[st_ff.cur] + dma_pkg::ADDR_W'(step_d);
               nxt_st.bus_addr = nxt_st.dst[st_ff.cur];
               nxt_st.beat = st_ff.beat + step_d;
               nxt_st.bus_wdata = st_ff.pack >> {nxt_st.beat[1:0], 3'h0};
               if (unit_done) begin
                  nxt_st.eng = dma_pkg::ENG_IDLE;
                  nxt_st.bus_req = 1'b0;
                  nxt_st.bus_we = 1'b0;
                  nxt_st.rem[st_ff.cur] = rem_dec;
                  if (rem_dec == (ch_count[st_ff.cur] >> 1))
                     nxt_st.flags[st_ff.cur][dma_pkg::FLAG_HT] = 1'b1;
                  if (rem_dec == '0) begin
                     nxt_st.flags[st_ff.cur][dma_pkg::FLAG_TC] = 1'b1;
                     if (ch_circular[st_ff.cur]) begin
                        nxt_st.rem[st_ff.cur] = ch_count[st_ff.cur];
                        nxt_st.src[st_ff.cur] = ch_src_addr[st_ff.cur];
                        nxt_st.dst[st_ff.cur] = ch_dst_addr[st_ff.cur];
                     end else begin
                        nxt_st.active[st_ff.cur] = 1'b0;
                     end
                  end
               end
            end
         end
         default: begin
            nxt_st.eng = dma_pkg::ENG_IDLE;
            nxt_st.bus_req = 1'b0;
         end
      endcase

      // Channel control last: a new request wins over the grant that clears it
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
         if (ch_enable[i] && !st_ff.en_d[i] && ch_count[i] != '0) begin
            nxt_st.active[i] = 1'b1;
            nxt_st.pend[i] = 1'b0;
            nxt_st.src[i] = ch_src_addr[i];
            nxt_st.dst[i] = ch_dst_addr[i];
            nxt_st.rem[i] = ch_count[i];
         end else if (!ch_enable[i]) begin
            nxt_st.active[i] = 1'b0;
         end
         if (routed_rise[i] && st_ff.active[i])
            nxt_st.pend[i] = 1'b1;
         nxt_st.irq[i] = |nxt_st.flags[i];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn)
         st_ff <= '0;
      else if (ce)
         st_ff <= nxt_st;
   end

   assign bus_req = st_ff.bus_req;
   assign bus_we = st_ff.bus_we;
   assign bus_size = st_ff.bus_size;
   assign bus_addr = st_ff.bus_addr;
   assign bus_wdata = st_ff.bus_wdata;
   assign ch_flags = st_ff.flags;
   assign ch_irq = st_ff.irq;
   assign ch_active = st_ff.active;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_route_pend;
      @(posedge clk) disable iff (!resetn)
         ce && |(routed_rise & st_ff.active) |=> &(st_ff.pend | ~$past(routed_rise & st_ff.active));
   endproperty
   a_route_pend: assert property (p_route_pend) else $error("routed request edge lost");

   property p_irq_or;
      @(posedge clk) disable iff (!resetn)
         ce ##1 1'b1 |-> ch_irq == {|ch_flags[6], |ch_flags[5], |ch_flags[4], |ch_flags[3],
                                   |ch_flags[2], |ch_flags[1], |ch_flags[0]};
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("interrupt differs from flag OR");

   property p_err_stop;
      @(posedge clk) disable iff (!resetn)
         ce && st_ff.eng != dma_pkg::ENG_IDLE && bus_err |=>
            !st_ff.active[$past(st_ff.cur)] && st_ff.flags[$past(st_ff.cur)][dma_pkg::FLAG_TE] && !bus_req;
   endproperty
   a_err_stop: assert property (p_err_stop) else $error("bus error did not stop channel");

   property p_count_dec;
      @(posedge clk) disable iff (!resetn)
         ce && unit_done && rem_dec != '0 |=> st_ff.rem[$past(st_ff.cur)] == $past(rem_dec);
   endproperty
   a_count_dec: assert property (p_count_dec) else $error("count not decremented by one");

   property p_circ_reload;
      @(posedge clk) disable iff (!resetn)
         ce && unit_done && rem_dec == '0 && ch_circular[st_ff.cur] |=>
            st_ff.rem[$past(st_ff.cur)] == $past(ch_count[st_ff.cur]) && st_ff.flags[$past(st_ff.cur)][dma_pkg::FLAG_TC];
   endproperty
   a_circ_reload: assert property (p_circ_reload) else $error("circular reload missed");

   property p_bus_size;
      @(posedge clk) disable iff (!resetn)
         bus_req |-> bus_size == (bus_we ? lg_d : lg_s);
   endproperty
   a_bus_size: assert property (p_bus_size) else $error("access size differs from element size");

   property p_grant_read;
      @(posedge clk) disable iff (!resetn)
         ce && st_ff.eng == dma_pkg::ENG_IDLE && arb.grant_valid |=>
            bus_req && !bus_we && bus_addr == $past(st_ff.src[arb.grant_idx]);
   endproperty
   a_grant_read: assert property (p_grant_read) else $error("grant did not start source read");
endmodule // dma_top
`default_nettype wire

/* prio_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
module prio_arbiter (
   input wire logic clk,     // System clock, assertions only
   input wire logic resetn,  // Synchronous reset, active low
   arb_if.arbiter a          // Request and grant bundle
);
   logic [1:0] best;
   logic found;
   logic [dma_pkg::CH_IDX_W-1:0] idx;
   logic higher_waiting;
   logic lower_tie;

   // ---------------------------------------------------------------
   // Selection
   // ---------------------------------------------------------------
   always_comb begin
      best = 2'h0;
      found = 1'b0;
      idx = '0;
      // Strict compare keeps the lowest index among equals
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
         if (a.req[i] && (!found || a.prio[i] > best)) begin
            found = 1'b1;
            best = a.prio[i];
            idx = dma_pkg::CH_IDX_W'(i);
         end
      end
      a.grant_idx = idx;
      a.grant_valid = found;
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   always_comb begin
      higher_waiting = 1'b0;
      lower_tie = 1'b0;
      for (int j = 0; j < dma_pkg::NUM_CH; j++) begin
         if (a.req[j] && a.prio[j] > a.prio[a.grant_idx])
            higher_waiting = 1'b1;
         if (a.req[j] && a.prio[j] == a.prio[a.grant_idx] && j < int'(a.grant_idx))
            lower_tie = 1'b1;
      end
   end

   property p_level_first;
      @(posedge clk) disable iff (!resetn) a.grant_valid |-> !higher_waiting && a.req[a.grant_idx];
   endproperty
   a_level_first: assert property (p_level_first) else $error("lower level granted over higher");

   property p_tie_low_index;
      @(posedge clk) disable iff (!resetn) a.grant_valid |-> !lower_tie;
   endproperty
   a_tie_low_index: assert property (p_tie_low_index) else $error("tie not broken by lowest channel");

   property p_no_idle_grant;
      @(posedge clk) disable iff (!resetn) (|a.req) |-> a.grant_valid;
   endproperty
   a_no_idle_grant: assert property (p_no_idle_grant) else $error("pending request without grant");
endmodule // prio_arbiter
`default_nettype wire

/* seven_channel_dma_with_request_router_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module seven_channel_dma_with_request_router_tb_top;
   localparam int NC = dma_pkg::NUM_CH;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [23:0] lines = '0;
   logic [NC-1:0] en = '0, circ = '0, m2m = '0;
   logic ce = 1'b1;
   logic [NC-1:0] sinc = '1, dinc = '1;
   dma_pkg::prio_type [NC-1:0] prio;
   logic [NC-1:0][1:0] ssz = '0, dsz = '0;
   logic [NC-1:0][4:0] sel = '0;
   logic [NC-1:0][31:0] src = '0, dst = '0;
   logic [NC-1:0][16:0] cnt = '0;
   logic [NC-1:0][2:0] fclr = '0;
   logic [1:0] wait_cyc = 2'h0;
   logic [31:0] err_addr = 32'hFFFF_FFFF, base = 32'h0001_0000;
   wire [NC-1:0][2:0] flags;
   wire [NC-1:0] irq, act;
   wire req, we, ack, err;
   wire [1:0] size;
   wire [31:0] addr, wdata, rdata;
   logic [31:0] wq[$];
   int n_mismatch = 0, compares = 0, cycles = 0;
   int ord[5] = '{5, 6, 3, 4, 2};

   dma_top dma_top_i (.clk(clk), .ce(ce), .resetn(resetn), .periph_req(lines[15:0]), .hw_trig(lines[23:16]),
      .ch_enable(en), .ch_circular(circ), .ch_mem2mem(m2m), .ch_src_inc(sinc), .ch_dst_inc(dinc),
      .ch_prio(prio), .ch_src_size(ssz), .ch_dst_size(dsz), .ch_req_sel(sel), .ch_src_addr(src),
      .ch_dst_addr(dst), .ch_count(cnt), .flag_clear(fclr), .bus_req(req), .bus_we(we), .bus_size(size),
      .bus_addr(addr), .bus_wdata(wdata), .bus_rdata(rdata), .bus_ack(ack), .bus_err(err),
      .ch_flags(flags), .ch_irq(irq), .ch_active(act));
   dma_mem_model dma_mem_model_i (.clk(clk), .bus_req(req), .bus_we(we), .bus_size(size), .bus_addr(addr),
      .bus_wdata(wdata), .wait_cyc(wait_cyc), .err_addr(err_addr), .bus_rdata(rdata), .bus_ack(ack),
      .bus_err(err));

   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (req && ack && we) wq.push_back(addr);
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cfg(input int c, input logic [1:0] s, input logic [1:0] d, input logic [16:0] n, input logic mm);
      ssz[c] = s;
      dsz[c] = d;
      cnt[c] = n;
      m2m[c] = mm;
      src[c] = base + 32'(c) * 32'h100; // Aligned to every size
      dst[c] = base + 32'h8000 + 32'(c) * 32'h100;
   endtask
   task automatic go(input logic [NC-1:0] m);
      en = en | m;
      tick(2);
   endtask
   // b below 3 waits for that flag, 3 waits for the channel to stop
   task automatic wait_on(input int c, input int b);
      int k;
      for (k = 0; k < 3000; k++) begin
         if ((b < 3) ? (flags[c][b] === 1'b1) : (act[c] === 1'b0)) break;
         tick(1);
      end
      `CHK(k < 3000, 1'b1)
   endtask
   task automatic chk_copy(input int c, input int nb);
      for (int i = 0; i < nb; i++) `CHK(dma_mem_model_i.mem[dst[c] + 32'(i)], 8'(src[c] + 32'(i)) ^ 8'hA5)
   endtask
   task automatic clear_all();
      en = '0;
      tick(1);
      fclr = '1;
      tick(1);
      fclr = '0;
      base = base + 32'h0001_0000;
      wq.delete();
   endtask
   task automatic report_and_stop();
      $display("Checks: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      for (int c = 0; c < NC; c++) prio[c] = dma_pkg::PRIO_LOW;
      tick(5);
      resetn = 1'b1;
      tick(4);
      cfg(0, dma_pkg::SIZE_BYTE, dma_pkg::SIZE_HALF, 17'h4, 1'b1);
      go(7'h01);
      wait_on(0, dma_pkg::FLAG_HT);
      `CHK(flags[0][dma_pkg::FLAG_TC], 1'b0)
      wait_on(0, 3);
      `CHK(flags[0], 3'h3)
      `CHK(irq[0], 1'b1)
      chk_copy(0, 8);
      // Slow slave while unpacking words into bytes
      clear_all();
      wait_cyc = 2'h2;
      cfg(1, dma_pkg::SIZE_WORD, dma_pkg::SIZE_BYTE, 17'h2, 1'b1);
      go(7'h02);
      wait_on(1, 3);
      chk_copy(1, 8);
      wait_cyc = 2'h0;
      // All four levels, with a tie at medium
      clear_all();
      for (int c = 2; c < 7; c++) cfg(c, dma_pkg::SIZE_BYTE, dma_pkg::SIZE_BYTE, 17'h1, 1'b1);
      prio[3] = dma_pkg::PRIO_MEDIUM;
      prio[4] = dma_pkg::PRIO_MEDIUM;
      prio[5] = dma_pkg::PRIO_VERY_HIGH;
      prio[6] = dma_pkg::PRIO_HIGH;
      go(7'h7C);
      wait_on(2, 3);
      `CHK(wq.size(), 5)
      for (int i = 0; i < 5; i++) `CHK(wq[i], dst[ord[i]])
      // One peripheral line, then one trigger line
      for (int i = 0; i < 2; i++) begin
         clear_all();
         cfg(i * 6, dma_pkg::SIZE_HALF, dma_pkg::SIZE_HALF, 17'h1, 1'b0);
         sel[i * 6] = i ? 5'h13 : 5'h09;
         go(7'(1 << (i * 6)));
         tick(20);
         `CHK(flags[i * 6], 3'h0)
         lines[i ? 19 : 9] = 1'b1;
         tick(3);
         lines = '0;
         wait_on(i * 6, dma_pkg::FLAG_TC);
         `CHK(flags[i * 6], 3'h3)
         chk_copy(i * 6, 2);
      end
      // Circular reload keeps the channel running
      clear_all();
      cfg(1, dma_pkg::SIZE_HALF, dma_pkg::SIZE_WORD, 17'h2, 1'b1);
      circ[1] = 1'b1;
      go(7'h02);
      wait_on(1, dma_pkg::FLAG_TC);
      fclr[1] = 3'h7;
      tick(1);
      fclr[1] = 3'h0;
      `CHK(flags[1], 3'h0)
      `CHK(irq[1], 1'b0)
      wait_on(1, dma_pkg::FLAG_TC);
      `CHK(act[1], 1'b1)
      chk_copy(1, 8);
      circ[1] = 1'b0;
      // Bus error on the second unit
      clear_all();
      cfg(0, dma_pkg::SIZE_WORD, dma_pkg::SIZE_WORD, 17'h3, 1'b1);
      err_addr = src[0] + 32'h4;
      go(7'h01);
      wait_on(0, 3);
      `CHK(flags[0], 3'h4)
      `CHK(irq[0], 1'b1)
      tick(5);
      `CHK(act[0], 1'b0)
      // Fixed peripheral ends, enabled while the clock enable holds all state
      clear_all();
      cfg(3, dma_pkg::SIZE_BYTE, dma_pkg::SIZE_BYTE, 17'h2, 1'b1);
      cfg(4, dma_pkg::SIZE_BYTE, dma_pkg::SIZE_BYTE, 17'h2, 1'b1);
      sinc[3] = 1'b0;
      dinc[4] = 1'b0;
      ce = 1'b0;
      go(7'h18);
      `CHK(act[4:3], 2'h0)
      ce = 1'b1;
      tick(2);
      `CHK(act[4:3], 2'h3)
      wait_on(3, 3);
      wait_on(4, 3);
      `CHK(dma_mem_model_i.mem[dst[3] + 32'h1], 8'hA5)
      `CHK(dma_mem_model_i.mem[dst[4]], 8'hA4)
      `CHK(dma_mem_model_i.mem.exists(dst[4] + 32'h1), 0)
      report_and_stop();
   end
endmodule // seven_channel_dma_with_request_router_tb_top
`default_nettype wire
